//--- common/asd_pkg.sv
// Shared constants and types for the address space decoder
package asd_pkg;

    // ------------------------------------------------------------
    // Register file space
    // ------------------------------------------------------------
    localparam int RF_ADDR_W = 12;
    localparam int RF_SIZE = 4096;
    localparam logic [11:0] RF_RAM_BASE = 12'h000;
    localparam logic [11:0] RF_CTL_BASE = 12'hF00;
    localparam logic [11:0] RF_CTL_LAST = 12'hFFF;
    localparam int RF_RAM_MAX = 3840;
    localparam int RF_RAM_MIN_BYTES = 2048;
    localparam int RF_RAM_MAX_BYTES = 4096;
    localparam int CTL_ADDR_W = 8;
    localparam logic [11:0] RF_PAGE_SEL_ADDR = 12'hFF0;
    localparam int PAGE_SEL_INFO_BIT = 7;
    localparam logic [7:0] RF_UNDEF_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Program memory space
    // ------------------------------------------------------------
    localparam int PM_ADDR_W = 16;
    localparam logic [7:0] PM_UNIMPL_BYTE = 8'hFF;
    localparam logic [15:0] PM_OPT_LAST = 16'h0001;
    localparam logic [15:0] PM_RST_VEC_LAST = 16'h0003;
    localparam logic [15:0] PM_WDT_VEC_LAST = 16'h0005;
    localparam logic [15:0] PM_TRAP_VEC_LAST = 16'h0007;
    localparam logic [15:0] PM_IRQ_VEC_LAST = 16'h0037;
    localparam logic [15:0] PM_TOP_16K = 16'h3FFF;
    localparam logic [15:0] PM_TOP_24K = 16'h5FFF;
    localparam logic [15:0] PM_TOP_32K = 16'h7FFF;
    localparam logic [15:0] PM_TOP_48K = 16'hBFFF;
    localparam logic [15:0] PM_TOP_64K = 16'hFFFF;

    // ------------------------------------------------------------
    // Information area
    // ------------------------------------------------------------
    localparam int INFO_ADDR_W = 9;
    localparam logic [15:0] INFO_BASE = 16'hFE00;
    localparam logic [15:0] INFO_LAST = 16'hFFFF;
    localparam logic [8:0] INFO_PART_BASE = 9'h040;
    localparam logic [8:0] INFO_PART_LAST = 9'h053;
    localparam int INFO_PART_LEN = 20;
    localparam logic [7:0] INFO_RSVD_BYTE = 8'hFF;
    localparam logic [7:0] INFO_NUL = 8'h00;

    // Flash size variants
    typedef enum logic [2:0] {
        ASD_FLASH_16K = 3'b000,
        ASD_FLASH_24K = 3'b001,
        ASD_FLASH_32K = 3'b010,
        ASD_FLASH_48K = 3'b011,
        ASD_FLASH_64K = 3'b100
    } asd_flash_t;

    // Program memory access kinds
    typedef enum logic [1:0] {
        ASD_PM_FETCH = 2'b00,
        ASD_PM_CONSTANT_LOAD = 2'b01,
        ASD_PM_CONSTANT_LOAD_INCREMENT = 2'b10,
        ASD_PM_DEBUG = 2'b11
    } asd_pm_kind_t;

    // Program memory region of an access
    typedef enum logic [2:0] {
        ASD_RG_OPTION = 3'b000,
        ASD_RG_RESET_VEC = 3'b001,
        ASD_RG_WDT_VEC = 3'b010,
        ASD_RG_TRAP_VEC = 3'b011,
        ASD_RG_IRQ_VEC = 3'b100,
        ASD_RG_CODE = 3'b101,
        ASD_RG_UNIMPL = 3'b110,
        ASD_RG_INFO = 3'b111
    } asd_region_t;

endpackage

//--- common/asd_info_if.sv
// Read path between the decoder and the information area store
`timescale 1ns/1ps
`default_nettype none

interface asd_info_if;
    logic [asd_pkg::INFO_ADDR_W-1:0] addr;
    logic [7:0] data;

    modport requester (output addr, input data);
    modport store (input addr, output data);
endinterface

`default_nettype wire

//--- hdl/asd_info_rom.sv
// Read-only information area store with the part identifier
`timescale 1ns/1ps
`default_nettype none

module asd_info_rom #(
    parameter logic [8*asd_pkg::INFO_PART_LEN-1:0] PART_ID = {"ASD0000", {13{8'h00}}} // Arbitrary value
) (
    asd_info_if.store info // Address in, byte out
);

    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    logic [8:0] part_idx;

    assign part_idx = info.addr - asd_pkg::INFO_PART_BASE;

    // First character sits at the lowest address, no write port exists
    always_comb begin
        if (info.addr >= asd_pkg::INFO_PART_BASE && info.addr <= asd_pkg::INFO_PART_LAST) begin
            info.data = PART_ID[8*(asd_pkg::INFO_PART_LEN-1-int'(part_idx)) +: 8];
        end else begin
            info.data = asd_pkg::INFO_RSVD_BYTE;
        end
    end

endmodule

`default_nettype wire

//--- hdl/asd_decoder.sv
// Address decoder for register file, program memory and data memory spaces
`timescale 1ns/1ps
`default_nettype none

module asd_decoder #(
    parameter int RAM_BYTES = asd_pkg::RF_RAM_MIN_BYTES, // Implemented RAM, 2048..4096
    parameter asd_pkg::asd_flash_t FLASH_SIZE = asd_pkg::ASD_FLASH_64K, // Flash variant
    parameter logic [8*asd_pkg::INFO_PART_LEN-1:0] PART_ID = {"ASD0000", {13{8'h00}}} // Arbitrary value
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    // Register file access from the CPU
    input wire logic rf_req, // Access request
    input wire logic rf_we, // Write when high
    input wire logic [11:0] rf_addr, // Register file address
    input wire logic [7:0] rf_wdata, // Write data
    output logic rf_ack, // Answer strobe
    output logic [7:0] rf_rdata, // Read data
    // Control register section towards the peripherals
    output logic ctl_req, // Control register access
    output logic ctl_we, // Control register write
    output logic [7:0] ctl_addr, // Offset within the section
    output logic [7:0] ctl_wdata, // Write data
    input wire logic [7:0] ctl_rdata, // Peripheral read data, same cycle
    input wire logic ctl_hit, // Offset is an implemented register
    output logic info_enable, // Information area overlay enabled
    // Program memory access from the CPU and debugger
    input wire logic pm_req, // Access request
    input wire logic pm_we, // Write when high
    input wire logic [1:0] pm_kind, // Access kind
    input wire logic [15:0] pm_addr, // Program address
    input wire logic [7:0] pm_wdata, // Write data
    output logic pm_ack, // Answer strobe
    output logic [7:0] pm_rdata, // Read data
    output logic [2:0] pm_region, // Region of the answered access
    // Flash array
    output logic flash_req, // Flash access
    output logic flash_we, // Flash write
    output logic [15:0] flash_addr, // Flash address
    output logic [7:0] flash_wdata, // Flash write data
    input wire logic [7:0] flash_rdata, // Flash read data, same cycle
    // Data memory access from the CPU
    input wire logic dm_req, // Access request
    input wire logic dm_we, // Write when high
    input wire logic [15:0] dm_addr, // Data address, ignored
    output logic dm_ack, // Answer strobe
    output logic [7:0] dm_rdata // Read data, always undefined value
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] flash_top(input asd_pkg::asd_flash_t sel);
        unique case (sel)
            asd_pkg::ASD_FLASH_16K: flash_top = asd_pkg::PM_TOP_16K;
            asd_pkg::ASD_FLASH_24K: flash_top = asd_pkg::PM_TOP_24K;
            asd_pkg::ASD_FLASH_32K: flash_top = asd_pkg::PM_TOP_32K;
            asd_pkg::ASD_FLASH_48K: flash_top = asd_pkg::PM_TOP_48K;
            asd_pkg::ASD_FLASH_64K: flash_top = asd_pkg::PM_TOP_64K;
            default: flash_top = asd_pkg::PM_TOP_16K;
        endcase
    endfunction

    function automatic logic in_ctl(input logic [11:0] a);
        in_ctl = (a >= asd_pkg::RF_CTL_BASE);
    endfunction

    function automatic logic in_ram(input logic [11:0] a);
        in_ram = (a < asd_pkg::RF_CTL_BASE) && (int'(a) < RAM_BYTES);
    endfunction

    function automatic logic in_overlay(input logic [15:0] a);
        in_overlay = (a >= asd_pkg::INFO_BASE) && (a <= asd_pkg::INFO_LAST);
    endfunction

    function automatic asd_pkg::asd_region_t region_of(input logic [15:0] a);
        if (a <= asd_pkg::PM_OPT_LAST) begin
            region_of = asd_pkg::ASD_RG_OPTION;
        end else if (a <= asd_pkg::PM_RST_VEC_LAST) begin
            region_of = asd_pkg::ASD_RG_RESET_VEC;
        end else if (a <= asd_pkg::PM_WDT_VEC_LAST) begin
            region_of = asd_pkg::ASD_RG_WDT_VEC;
        end else if (a <= asd_pkg::PM_TRAP_VEC_LAST) begin
            region_of = asd_pkg::ASD_RG_TRAP_VEC;
        end else if (a <= asd_pkg::PM_IRQ_VEC_LAST) begin
            region_of = asd_pkg::ASD_RG_IRQ_VEC;
        end else begin
            region_of = asd_pkg::ASD_RG_CODE;
        end
    endfunction

    localparam logic [15:0] FLASH_LAST = flash_top(FLASH_SIZE);

    // ------------------------------------------------------------
    // Register file decode
    // ------------------------------------------------------------
    logic [7:0] ram [0:asd_pkg::RF_RAM_MAX-1];
    logic rf_ctl_sel;
    logic rf_ram_sel;
    logic rf_page_sel;
    logic [7:0] next_rf_rdata;

    assign rf_ctl_sel = rf_req && in_ctl(rf_addr);
    assign rf_ram_sel = rf_req && in_ram(rf_addr);
    assign rf_page_sel = rf_req && (rf_addr == asd_pkg::RF_PAGE_SEL_ADDR);

    // Peripherals see the low byte of the control section address
    assign ctl_req = rf_ctl_sel;
    assign ctl_we = rf_ctl_sel && rf_we;
    assign ctl_addr = rf_addr[asd_pkg::CTL_ADDR_W-1:0];
    assign ctl_wdata = rf_wdata;

    always_comb begin
        if (rf_page_sel) begin
            next_rf_rdata = {info_enable, 7'h00};
        end else if (rf_ctl_sel) begin
            next_rf_rdata = ctl_hit ? ctl_rdata : asd_pkg::RF_UNDEF_BYTE;
        end else if (rf_ram_sel) begin
            next_rf_rdata = ram[rf_addr];
        end else begin
            next_rf_rdata = asd_pkg::RF_UNDEF_BYTE;
        end
    end

    // RAM storage; gap writes fall through untouched
    always_ff @(posedge sys_clk) begin
        if (rf_ram_sel && rf_we) begin
            ram[rf_addr] <= rf_wdata;
        end
    end

    // Register file answer, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rf_ack <= 1'b0;
            rf_rdata <= 8'h00;
        end else begin
            rf_ack <= rf_req;
            if (rf_req && !rf_we) begin
                rf_rdata <= next_rf_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Overlay enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            info_enable <= 1'b0;
        end else if (rf_page_sel && rf_we) begin
            info_enable <= rf_wdata[asd_pkg::PAGE_SEL_INFO_BIT];
        end
    end

    // ------------------------------------------------------------
    // Program memory decode
    // ------------------------------------------------------------
    asd_info_if info_bus ();

    asd_info_rom #(
        .PART_ID(PART_ID)
    ) u_info_rom (
        .info(info_bus.store)
    );

    logic pm_impl;
    logic pm_overlay;
    asd_pkg::asd_region_t next_region;
    logic [7:0] next_pm_rdata;

    assign pm_impl = (pm_addr <= FLASH_LAST);
    // Fetches bypass the overlay
    assign pm_overlay = info_enable && in_overlay(pm_addr)
        && (asd_pkg::asd_pm_kind_t'(pm_kind) != asd_pkg::ASD_PM_FETCH);
    assign info_bus.addr = pm_addr[asd_pkg::INFO_ADDR_W-1:0];

    // Flash sees only implemented addresses outside an active overlay
    assign flash_req = pm_req && pm_impl && !pm_overlay;
    assign flash_we = flash_req && pm_we;
    assign flash_addr = pm_addr;
    assign flash_wdata = pm_wdata;

    always_comb begin
        if (pm_overlay) begin
            next_region = asd_pkg::ASD_RG_INFO;
            next_pm_rdata = info_bus.data;
        end else if (!pm_impl) begin
            next_region = asd_pkg::ASD_RG_UNIMPL;
            next_pm_rdata = asd_pkg::PM_UNIMPL_BYTE;
        end else begin
            next_region = region_of(pm_addr);
            next_pm_rdata = flash_rdata;
        end
    end

    // Program memory answer, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pm_ack <= 1'b0;
            pm_rdata <= 8'h00;
            pm_region <= asd_pkg::ASD_RG_OPTION;
        end else begin
            pm_ack <= pm_req;
            if (pm_req) begin
                pm_region <= next_region;
                if (!pm_we) begin
                    pm_rdata <= next_pm_rdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory space
    // ------------------------------------------------------------
    logic dm_unused;

    assign dm_unused = dm_we ^ (^dm_addr);

    // Answered so the CPU never stalls, but nothing is stored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dm_ack <= 1'b0;
            dm_rdata <= 8'h00;
        end else begin
            dm_ack <= dm_req;
            dm_rdata <= asd_pkg::RF_UNDEF_BYTE;
        end
    end

endmodule

`default_nettype wire

//--- tb/asd_decoder_checker.sv
// Port assertions for the address space decoder
`timescale 1ns/1ps
`default_nettype none
module asd_decoder_checker #(
    parameter int RAM_BYTES = 2048,
    parameter asd_pkg::asd_flash_t FLASH_SIZE = asd_pkg::ASD_FLASH_64K
) (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset, active high
    input wire logic rf_req, // Register file request
    input wire logic rf_we, // Register file write
    input wire logic rf_ack, // Register file answer
    input wire logic [11:0] rf_addr, // Register file address
    input wire logic [7:0] rf_wdata, // Register file write data
    input wire logic [7:0] rf_rdata, // Register file read data
    input wire logic ctl_req, // Control access
    input wire logic ctl_we, // Control write
    input wire logic [7:0] ctl_addr, // Control offset
    input wire logic [7:0] ctl_wdata, // Control write data
    input wire logic info_enable, // Overlay enable
    input wire logic pm_req, // Program memory request
    input wire logic pm_we, // Program memory write
    input wire logic pm_ack, // Program memory answer
    input wire logic [1:0] pm_kind, // Access kind
    input wire logic [15:0] pm_addr, // Program address
    input wire logic [7:0] pm_wdata, // Program write data
    input wire logic [7:0] pm_rdata, // Program read data
    input wire logic [2:0] pm_region, // Answered region
    input wire logic flash_req, // Flash access
    input wire logic flash_we, // Flash write
    input wire logic [15:0] flash_addr, // Flash address
    input wire logic [7:0] flash_wdata, // Flash write data
    input wire logic dm_req, // Data memory request
    input wire logic dm_ack, // Data memory answer
    input wire logic [7:0] dm_rdata // Data memory read data
);
    localparam logic [15:0] TOP = FLASH_SIZE == asd_pkg::ASD_FLASH_16K ? asd_pkg::PM_TOP_16K :
        FLASH_SIZE == asd_pkg::ASD_FLASH_24K ? asd_pkg::PM_TOP_24K :
        FLASH_SIZE == asd_pkg::ASD_FLASH_32K ? asd_pkg::PM_TOP_32K :
        FLASH_SIZE == asd_pkg::ASD_FLASH_48K ? asd_pkg::PM_TOP_48K : asd_pkg::PM_TOP_64K;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    wire ovl = info_enable && pm_kind != 2'b00 && pm_addr >= 16'hFE00;

    sequence s_info_ans;
        pm_ack && pm_region == 3'd7;
    endsequence
    sequence s_unimpl_ans;
        pm_ack && pm_rdata == 8'hFF && pm_region == 3'd6;
    endsequence

    chk_rf_answer: assert property (rf_req |=> rf_ack)
        else $error("register file answer missing");
    chk_ctl_route: assert property (rf_req && rf_addr >= 12'hF00 |-> ctl_req && ctl_addr == rf_addr[7:0])
        else $error("control access not routed");
    chk_ctl_write: assert property (rf_req && rf_addr >= 12'hF00 |-> ctl_we == rf_we && ctl_wdata == rf_wdata)
        else $error("control write not forwarded");
    chk_ram_gap: assert property (rf_req && !rf_we && rf_addr >= RAM_BYTES && rf_addr < 12'hF00 |=>
        rf_rdata == 8'h00)
        else $error("gap read not undefined value");
    chk_pm_unimpl: assert property (pm_req && !pm_we && !ovl && pm_addr > TOP |-> !flash_req ##1 s_unimpl_ans)
        else $error("unimplemented read wrong");
    chk_pm_nowrite: assert property (pm_req && pm_we && pm_addr > TOP |-> !flash_req)
        else $error("unimplemented write reached flash");
    chk_fetch_flash: assert property (pm_req && pm_kind == 2'b00 && pm_addr <= TOP |->
        flash_req && flash_addr == pm_addr)
        else $error("fetch not from flash");
    chk_flash_pass: assert property (flash_req |-> flash_we == pm_we && flash_wdata == pm_wdata)
        else $error("flash write path wrong");
    chk_overlay_read: assert property (pm_req && !pm_we && ovl |-> !flash_req ##1 s_info_ans)
        else $error("overlay read not from info area");
    chk_info_ro: assert property (pm_req && pm_we && ovl |-> !flash_req)
        else $error("info area write passed");
    chk_dm_empty: assert property (dm_req |=> dm_ack && dm_rdata == 8'h00)
        else $error("data memory answer wrong");
    chk_reset_off: assert property (disable iff (1'b0) rst |=> !info_enable)
        else $error("overlay enabled after reset");
endmodule

bind asd_decoder asd_decoder_checker #(.RAM_BYTES(RAM_BYTES), .FLASH_SIZE(FLASH_SIZE)) u_chk (
    .sys_clk, .rst, .rf_req, .rf_we, .rf_ack, .rf_addr, .rf_wdata, .rf_rdata, .ctl_req, .ctl_we, .ctl_addr,
    .ctl_wdata, .info_enable, .pm_req, .pm_we, .pm_ack, .pm_kind, .pm_addr, .pm_wdata, .pm_rdata, .pm_region,
    .flash_req, .flash_we, .flash_addr, .flash_wdata, .dm_req, .dm_ack, .dm_rdata);
`default_nettype wire

//--- tb/asd_far_model.sv
// Flash array and peripheral register model behind the decoder
`timescale 1ns/1ps
`default_nettype none
module asd_far_model (
    input wire logic sys_clk, // Clock
    input wire logic flash_req, // Flash access
    input wire logic flash_we, // Flash write
    input wire logic [15:0] flash_addr, // Flash address
    input wire logic ctl_req, // Control access
    input wire logic [7:0] ctl_addr, // Control offset
    output logic [7:0] flash_rdata, // Flash data
    output logic [7:0] ctl_rdata, // Peripheral data
    output logic ctl_hit, // Implemented offset
    output var int n_flash_wr // Flash writes seen
);
    wire [7:0] fpat = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
    wire [7:0] cpat = ctl_addr ^ 8'hA5;
    // Unselected lines show the inverse so a stale value never matches
    assign flash_rdata = flash_req && !flash_we ? fpat : ~fpat;
    assign ctl_rdata = ctl_req ? cpat : ~cpat;
    // Only offsets 00..1F are implemented, the rest are reserved
    assign ctl_hit = ctl_req && ctl_addr < 8'h20;
    int n_wr = 0;
    assign n_flash_wr = n_wr;
    always @(posedge sys_clk) begin
        if (flash_req && flash_we) begin
            n_wr <= n_wr + 1;
        end
    end
endmodule
`default_nettype wire

//--- tb/test_address_space_decoder.sv
// Self-checking testbench for the address space decoder
`timescale 1ns/1ps
`default_nettype none
module test_address_space_decoder;
    localparam int RAMB = 2048;
    localparam logic [159:0] ID = {"TB_PART_01", {10{8'h00}}}; // Arbitrary value
    localparam logic [15:0] MAP_A [12] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0006, 16'h0007,
        16'h0008, 16'h0037, 16'h0038, 16'h7FFF, 16'h8000, 16'hFFFF};
    localparam logic [2:0] MAP_R [12] = '{3'd0, 3'd0, 3'd1, 3'd2, 3'd3, 3'd3, 3'd4, 3'd4, 3'd5, 3'd5, 3'd6, 3'd6};
    logic sys_clk = 0, rst = 1, rf_req = 0, rf_we = 0, pm_req = 0, pm_we = 0, dm_req = 0, dm_we = 0;
    logic [11:0] rf_addr = 0;
    logic [7:0] rf_wdata = 0, pm_wdata = 0, rf_rdata, ctl_addr, ctl_rdata, pm_rdata, flash_rdata, dm_rdata;
    logic [1:0] pm_kind = 0;
    logic [15:0] pm_addr = 0, dm_addr = 0, flash_addr;
    logic rf_ack, ctl_req, ctl_hit, info_enable, pm_ack, flash_req, flash_we, dm_ack;
    logic [2:0] pm_region;
    int err_total = 0, n_compared = 0, n_flash_wr, w0;

    asd_decoder #(.RAM_BYTES(RAMB), .FLASH_SIZE(asd_pkg::ASD_FLASH_32K), .PART_ID(ID)) u_dut (
        .sys_clk, .rst, .rf_req, .rf_we, .rf_addr, .rf_wdata, .rf_ack, .rf_rdata, .ctl_req, .ctl_we(),
        .ctl_addr, .ctl_wdata(), .ctl_rdata, .ctl_hit, .info_enable, .pm_req, .pm_we, .pm_kind, .pm_addr,
        .pm_wdata, .pm_ack, .pm_rdata, .pm_region, .flash_req, .flash_we, .flash_addr, .flash_wdata(),
        .flash_rdata, .dm_req, .dm_we, .dm_addr, .dm_ack, .dm_rdata);
    asd_far_model u_far (.sys_clk, .flash_req, .flash_we, .flash_addr, .ctl_req, .ctl_addr,
        .flash_rdata, .ctl_rdata, .ctl_hit, .n_flash_wr);

    always #5 sys_clk = ~sys_clk;

    function automatic logic [7:0] fpat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rf_op(input logic we, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {rf_req, rf_we, rf_addr, rf_wdata} <= {1'b1, we, a, d};
        @(posedge sys_clk);
        rf_req <= 0;
        #1 cmp8({7'b0, rf_ack}, 8'h01, "rf_ack");
    endtask
    task automatic rf_rd(input logic [11:0] a, input logic [7:0] exp);
        rf_op(0, a, 8'h00);
        cmp8(rf_rdata, exp, "rf_rdata");
    endtask
    task automatic pm_op(input logic we, input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {pm_req, pm_we, pm_kind, pm_addr, pm_wdata} <= {1'b1, we, k, a, d};
        @(posedge sys_clk);
        pm_req <= 0;
        #1 cmp8({7'b0, pm_ack}, 8'h01, "pm_ack");
    endtask
    task automatic pm_rd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] exp, input logic [2:0] rg);
        pm_op(0, k, a, 8'h00);
        cmp8(pm_rdata, exp, "pm_rdata");
        cmp8({5'b0, pm_region}, {5'b0, rg}, "pm_region");
    endtask

    task automatic t_reset;
        cmp8({7'b0, info_enable}, 8'h00, "info_enable");
        rf_rd(12'hFF0, 8'h00);
        pm_rd(2'b01, 16'hFE40, 8'hFF, 3'd6);
        pm_rd(2'b01, 16'h1234, fpat(16'h1234), 3'd5);
        $display("test reset done");
    endtask
    task automatic t_regfile;
        rf_op(1, 12'h000, 8'h3C);
        rf_rd(12'h000, 8'h3C);
        rf_op(1, 12'(RAMB - 1), 8'hC3);
        rf_rd(12'(RAMB - 1), 8'hC3);
        rf_op(1, 12'(RAMB), 8'h77);
        rf_rd(12'(RAMB), 8'h00);
        rf_rd(12'h000, 8'h3C);
        rf_rd(12'hEFF, 8'h00);
        rf_rd(12'hF05, 8'h05 ^ 8'hA5);
        rf_rd(12'hF1F, 8'h1F ^ 8'hA5);
        rf_rd(12'hF30, 8'h00);
        rf_rd(12'hFFF, 8'h00);
        $display("test register file done");
    endtask
    task automatic t_pmmap;
        for (int i = 0; i < 12; i++) begin
            pm_rd(2'b00, MAP_A[i], MAP_R[i] == 3'd6 ? 8'hFF : fpat(MAP_A[i]), MAP_R[i]);
        end
        w0 = n_flash_wr;
        pm_op(1, 2'b01, 16'h9000, 8'h55);
        cmp8(8'(n_flash_wr - w0), 8'h00, "flash writes");
        pm_op(1, 2'b01, 16'h1000, 8'h55);
        cmp8(8'(n_flash_wr - w0), 8'h01, "flash writes");
        $display("test program map done");
    endtask
    task automatic t_overlay;
        rf_op(1, 12'hFF0, 8'h80);
        cmp8({7'b0, info_enable}, 8'h01, "info_enable");
        rf_rd(12'hFF0, 8'h80);
        for (int k = 1; k < 4; k++) begin
            for (int i = 0; i < 20; i++) begin
                pm_rd(2'(k), 16'(16'hFE40 + i), ID[159 - 8 * i -: 8], 3'd7);
            end
        end
        pm_rd(2'b01, 16'hFE00, 8'hFF, 3'd7);
        pm_rd(2'b11, 16'hFE3F, 8'hFF, 3'd7);
        pm_rd(2'b10, 16'hFE54, 8'hFF, 3'd7);
        pm_rd(2'b01, 16'hFFFF, 8'hFF, 3'd7);
        pm_rd(2'b01, 16'hFDFF, 8'hFF, 3'd6);
        pm_rd(2'b00, 16'hFE40, 8'hFF, 3'd6);
        w0 = n_flash_wr;
        pm_op(1, 2'b01, 16'hFE40, 8'h00);
        pm_rd(2'b01, 16'hFE40, ID[159 -: 8], 3'd7);
        cmp8(8'(n_flash_wr - w0), 8'h00, "flash writes");
        rf_op(1, 12'hFF0, 8'h7F);
        rf_rd(12'hFF0, 8'h00);
        pm_rd(2'b01, 16'hFE40, 8'hFF, 3'd6);
        rf_op(1, 12'hFF0, 8'h80);
        @(posedge sys_clk);
        rst <= 1;
        @(posedge sys_clk);
        rst <= 0;
        #1 cmp8({7'b0, info_enable}, 8'h00, "info_enable");
        $display("test overlay done");
    endtask
    task automatic t_dm;
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            {dm_req, dm_we, dm_addr} <= {1'b1, i == 0, 16'h0100};
            @(posedge sys_clk);
            dm_req <= 0;
            #1 cmp8({7'b0, dm_ack}, 8'h01, "dm_ack");
            cmp8(dm_rdata, 8'h00, "dm_rdata");
        end
        $display("test data memory done");
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #50000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 0;
        t_reset;
        t_regfile;
        t_pmmap;
        t_overlay;
        t_dm;
        stop_test;
    end
endmodule
`default_nettype wire
